/* wl_pkg.sv */
// Constants and carrier types of the write leveling block
package wl_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int MODE_SET_NS   = 480;  // Mode-set delay, least time
   localparam int MODE_SET_CYC  =
      (MODE_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FB_DELAY_NS   = 40;   // feedback_output_delay, longest
   localparam int FB_DELAY_RAW  = FB_DELAY_NS / CLK_PERIOD_NS;
   localparam int FB_DELAY_CYC  = (FB_DELAY_RAW < 1) ? 1 : FB_DELAY_RAW;

   // Register map
   localparam logic [7:0]  ADDR_MR1    = 8'h00;
   localparam logic [7:0]  ADDR_STATUS = 8'h04;
   localparam int          MR1_WIDTH   = 13;
   localparam int          MR1_WL_BIT  = 7;   // Leveling enable
   localparam int          MR1_QOFF_BIT = 12; // Output buffer off
   localparam logic [12:0] MR1_RESET   = 13'h0000;

   // Status register fields
   localparam int ST_WL_BIT    = 0;
   localparam int ST_UNDEF_BIT = 1;
   localparam int ST_FB_LO_BIT = 2;
   localparam int ST_FB_HI_BIT = 3;
   localparam int ST_NOM_BIT   = 4;
   localparam int ST_PARK_BIT  = 5;

   // Leveling sequence states
   typedef enum logic [1:0] {
      ST_OFF,
      ST_SETTLE,
      ST_LEVEL,
      ST_EXIT
   } wl_state_t;

   // One strobe sample of a lane
   typedef struct packed {
      logic valid;
      logic level;
   } sample_t;

   // Termination state of the pins
   typedef struct packed {
      logic nom;
      logic park;
      logic dq;
   } term_t;
endpackage

/* wl_sampler.sv */
// Per-lane rising strobe detector that captures the clock level
`timescale 1ns/100ps
`default_nettype none
module wl_sampler #(
   parameter int LANES = 2
) (
   input  wire logic                         sys_clk,
   input  wire logic                         nrst,
   input  wire logic                         enable,
   input  wire logic [LANES-1:0]             strobe,
   input  wire logic                         ck_level,
   output var  wl_pkg::sample_t [LANES-1:0]  smp_q
);
   logic [LANES-1:0]            strobe_q;
   logic [LANES-1:0]            strobe_d;
   wl_pkg::sample_t [LANES-1:0] smp_d;

   // Rising edge of each lane strobe samples the clock level
   always_comb begin
      strobe_d = strobe;
      for (int i = 0; i < LANES; i++) begin
         smp_d[i].valid = enable && strobe[i] && !strobe_q[i];
         smp_d[i].level = ck_level;
      end
   end

   // Register the samples
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         strobe_q <= '0;
         smp_q    <= '0;
      end else begin
         strobe_q <= strobe_d;
         smp_q    <= smp_d;
      end
   end
endmodule // wl_sampler
`default_nettype wire

/* wl_delay.sv */
// Fixed pipeline that holds back feedback samples
`timescale 1ns/100ps
`default_nettype none
module wl_delay #(
   parameter int LANES = 2,
   parameter int DEPTH = 2
) (
   input  wire logic                         sys_clk,
   input  wire logic                         nrst,
   input  wire logic                         flush,
   input  wire wl_pkg::sample_t [LANES-1:0]  din,
   output var  wl_pkg::sample_t [LANES-1:0]  dout
);
   wl_pkg::sample_t [LANES-1:0] pipe_q [DEPTH];
   wl_pkg::sample_t [LANES-1:0] pipe_d [DEPTH];

   // Shift one stage per cycle; flush drops samples in flight
   always_comb begin
      for (int s = 0; s < DEPTH; s++) begin
         if (flush) begin
            pipe_d[s] = '0;
         end else if (s == 0) begin
            pipe_d[s] = din;
         end else begin
            pipe_d[s] = pipe_q[s-1];
         end
      end
   end

   // Register the stages
   always_ff @(posedge sys_clk) begin
      for (int s = 0; s < DEPTH; s++) begin
         if (!nrst) begin
            pipe_q[s] <= '0;
         end else begin
            pipe_q[s] <= pipe_d[s];
         end
      end
   end

   assign dout = pipe_q[DEPTH-1];
endmodule // wl_delay
`default_nettype wire

/* wl_level.sv */
// Write leveling logic of the memory device with an APB register port
//
// Contract
// - Mode bit A7 enters and leaves leveling
// - Mode bit A12 turns data outputs off
// - Termination pin switches only strobe termination
// - Data pins undefined until feedback starts
// - Exit write may change other mode bits
// - Strobe edge samples clock, data bits report
// - Feedback bit skew within skew window
// - Feedback one for clock high, zero low
// - Each lane reports its own strobe
// - Data undefined for mode-set delay after exit
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module wl_level #(
   parameter int LANES = 2,
   parameter int LANE_BITS = 8
) (
   input  wire logic                         sys_clk,
   input  wire logic                         nrst,
   input  wire logic [7:0]                   paddr,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         ck_level,
   input  wire logic                         odt,
   input  wire logic [LANES-1:0]             strobe,
   output logic      [LANES*LANE_BITS-1:0]   dq_o,
   output logic      [LANES*LANE_BITS-1:0]   dq_oe,
   output logic      [LANES-1:0]             strobe_oe,
   output logic                              dqs_term_nom,
   output logic                              dqs_term_park,
   output logic                              dq_term_on,
   output logic                              dq_undef,
   output logic                              wl_active
);
   localparam int DQW    = LANES * LANE_BITS;
   localparam int CNT_W  = $clog2(wl_pkg::MODE_SET_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD =
      CNT_W'(wl_pkg::MODE_SET_CYC - 1);
   localparam int FB_LAT = wl_pkg::FB_DELAY_CYC + 2;

   // Bus and mode state
   logic [31:0]               prdata_q, prdata_d;
   logic                      pready_q, pready_d;
   logic                      pslverr_q, pslverr_d;
   logic [12:0]               mr1_q, mr1_d;
   wl_pkg::wl_state_t         state_q, state_d;
   logic [CNT_W-1:0]          cnt_q, cnt_d;
   // Pin state
   logic [DQW-1:0]            dq_q, dq_d;
   logic [DQW-1:0]            dq_oe_q, dq_oe_d;
   logic [LANES-1:0]          fb_lvl_q, fb_lvl_d;
   logic                      fb_seen_q, fb_seen_d;
   wl_pkg::term_t             term_q, term_d;
   logic                      undef_q, undef_d;
   logic                      wl_act_q, wl_act_d;
   // Internal nets
   logic                      access;
   logic                      mr1_wr;
   logic [12:0]               wr_val;
   logic                      wr_enter;
   logic                      wr_exit;
   logic                      in_level;
   logic                      qoff;
   wl_pkg::sample_t [LANES-1:0] smp;
   wl_pkg::sample_t [LANES-1:0] fb;

   // Address decode of a mapped register
   function automatic logic mapped(input logic [7:0] a);
      return (a == wl_pkg::ADDR_MR1) || (a == wl_pkg::ADDR_STATUS);
   endfunction

   // Completing access phase and mode register write decode
   assign access   = psel && penable && pready_q;
   assign mr1_wr   = access && pwrite && (paddr == wl_pkg::ADDR_MR1);
   assign wr_val   = pwdata[wl_pkg::MR1_WIDTH-1:0];
   assign wr_enter = mr1_wr && wr_val[wl_pkg::MR1_WL_BIT];
   assign wr_exit  = mr1_wr && !wr_val[wl_pkg::MR1_WL_BIT];
   assign in_level = (state_q == wl_pkg::ST_LEVEL);
   assign qoff     = mr1_q[wl_pkg::MR1_QOFF_BIT];

   // Strobe edge capture and feedback output delay
   wl_sampler #(
      .LANES    (LANES)
   ) u_sampler (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .enable   (in_level),
      .strobe   (strobe),
      .ck_level (ck_level),
      .smp_q    (smp)
   );

   wl_delay #(
      .LANES   (LANES),
      .DEPTH   (wl_pkg::FB_DELAY_CYC)
   ) u_delay (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .flush   (!in_level),
      .din     (smp),
      .dout    (fb)
   );

   // APB slave: one wait state, error on unmapped address
   always_comb begin
      pready_d  = psel && penable && !pready_q;
      pslverr_d = pready_d && !mapped(paddr);
      prdata_d  = 32'h0000_0000;
      if (pready_d && !pwrite && paddr == wl_pkg::ADDR_MR1) begin
         prdata_d[wl_pkg::MR1_WIDTH-1:0] = mr1_q;
      end else if (pready_d && !pwrite &&
                   paddr == wl_pkg::ADDR_STATUS) begin
         prdata_d[wl_pkg::ST_WL_BIT]    = wl_act_q;
         prdata_d[wl_pkg::ST_UNDEF_BIT] = undef_q;
         prdata_d[wl_pkg::ST_FB_LO_BIT] = fb_lvl_q[0];
         prdata_d[wl_pkg::ST_FB_HI_BIT] = fb_lvl_q[LANES-1];
         prdata_d[wl_pkg::ST_NOM_BIT]   = term_q.nom;
         prdata_d[wl_pkg::ST_PARK_BIT]  = term_q.park;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   // Mode register and leveling sequence
   always_comb begin
      mr1_d   = mr1_q;
      state_d = state_q;
      cnt_d   = cnt_q;
      if (mr1_wr) begin
         if (!mr1_q[wl_pkg::MR1_WL_BIT] || wr_exit) begin
            mr1_d = wr_val;
         end else begin
            mr1_d[wl_pkg::MR1_QOFF_BIT] = wr_val[wl_pkg::MR1_QOFF_BIT];
         end
      end
      case (state_q)
         wl_pkg::ST_OFF: begin
            if (wr_enter) begin
               state_d = wl_pkg::ST_SETTLE;
               cnt_d   = CNT_LOAD;
            end
         end
         wl_pkg::ST_SETTLE: begin
            if (wr_exit) begin
               state_d = wl_pkg::ST_EXIT;
               cnt_d   = CNT_LOAD;
            end else if (cnt_q == '0) begin
               state_d = wl_pkg::ST_LEVEL;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         wl_pkg::ST_LEVEL: begin
            if (wr_exit) begin
               state_d = wl_pkg::ST_EXIT;
               cnt_d   = CNT_LOAD;
            end
         end
         wl_pkg::ST_EXIT: begin
            if (wr_enter) begin
               state_d = wl_pkg::ST_SETTLE;
               cnt_d   = CNT_LOAD;
            end else if (cnt_q == '0) begin
               state_d = wl_pkg::ST_OFF;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            state_d = wl_pkg::ST_OFF;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         mr1_q   <= wl_pkg::MR1_RESET;
         state_q <= wl_pkg::ST_OFF;
         cnt_q   <= '0;
      end else begin
         mr1_q   <= mr1_d;
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Feedback drive, termination and pin status
   always_comb begin
      fb_lvl_d  = fb_lvl_q;
      fb_seen_d = fb_seen_q && in_level;
      for (int l = 0; l < LANES; l++) begin
         if (!in_level) begin
            fb_lvl_d[l] = 1'b0;
         end else if (fb[l].valid) begin
            fb_lvl_d[l] = fb[l].level;
            fb_seen_d   = 1'b1;
         end
      end
      for (int b = 0; b < DQW; b++) begin
         // each lane from its own strobe
         dq_d[b]    = fb_lvl_d[b / LANE_BITS];
         dq_oe_d[b] = in_level && fb_seen_d && !qoff;
      end
      undef_d  = (state_q != wl_pkg::ST_OFF) && !(in_level && fb_seen_d);
      wl_act_d = mr1_q[wl_pkg::MR1_WL_BIT];
      term_d.nom  = odt;
      term_d.park = !odt;
      term_d.dq   = !mr1_q[wl_pkg::MR1_WL_BIT];
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         fb_lvl_q  <= '0;
         fb_seen_q <= 1'b0;
         dq_q      <= '0;
         dq_oe_q   <= '0;
         undef_q   <= 1'b0;
         wl_act_q  <= 1'b0;
         term_q    <= '0;
      end else begin
         fb_lvl_q  <= fb_lvl_d;
         fb_seen_q <= fb_seen_d;
         dq_q      <= dq_d;
         dq_oe_q   <= dq_oe_d;
         undef_q   <= undef_d;
         wl_act_q  <= wl_act_d;
         term_q    <= term_d;
      end
   end

   // Outputs straight from flops; read strobes never driven here
   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign dq_o          = dq_q;
   assign dq_oe         = dq_oe_q;
   assign strobe_oe     = '0;
   assign dqs_term_nom  = term_q.nom;
   assign dqs_term_park = term_q.park;
   assign dq_term_on    = term_q.dq;
   assign dq_undef      = undef_q;
   assign wl_active     = wl_act_q;

   // Helper: previous strobe level for edge checks
   logic [LANES-1:0] stb_prev_q;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         stb_prev_q <= '0;
      end else begin
         stb_prev_q <= strobe;
      end
   end

   AST_ENTER: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wr_enter && state_q == wl_pkg::ST_OFF)
      |=> ##1 (wl_act_q && state_q == wl_pkg::ST_SETTLE))
      else $error("leveling not entered");

   AST_EXIT: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wr_exit && in_level) |=> (state_q == wl_pkg::ST_EXIT) ##1 !wl_act_q)
      else $error("leveling not left");

   AST_QOFF: assert property (@(posedge sys_clk) disable iff (!nrst)
      (qoff && $stable(qoff)) |=> (dq_oe_q == '0))
      else $error("data driven with outputs off");

   AST_TERM: assert property (@(posedge sys_clk) disable iff (!nrst)
      (mr1_q[wl_pkg::MR1_WL_BIT] && $stable(mr1_q))
      |=> (!dq_term_on && dqs_term_nom == $past(odt)
           && dqs_term_park != $past(odt)))
      else $error("wrong termination in leveling");

   AST_UNDEF: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == wl_pkg::ST_OFF && wr_enter)
      |=> ##1 ((dq_oe_q == '0) && dq_undef) [*8])
      else $error("data driven before feedback");

   AST_FB_LO: assert property (@(posedge sys_clk) disable iff (!nrst)
      (in_level && strobe[0] && !stb_prev_q[0] && ck_level)
      |-> ##FB_LAT (dq_q[LANE_BITS-1:0] == '1 || !in_level
                    || $past(wr_exit, FB_LAT)))
      else $error("clock high not reported");

   AST_FB_HI: assert property (@(posedge sys_clk) disable iff (!nrst)
      (in_level && strobe[LANES-1] && !stb_prev_q[LANES-1] && !ck_level)
      |-> ##FB_LAT (dq_q[DQW-1 -: LANE_BITS] == '0 || !in_level))
      else $error("upper lane not reported");

   AST_SKEW: assert property (@(posedge sys_clk) disable iff (!nrst)
      (dq_q[LANE_BITS-1:0] == '0 || dq_q[LANE_BITS-1:0] == '1)
      && (dq_oe_q == '0 || dq_oe_q == '1))
      else $error("feedback bits disagree");

   AST_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
      (in_level && $past(in_level) && !fb[0].valid && !fb[LANES-1].valid)
      |=> $stable(dq_q))
      else $error("feedback not held");

   AST_KEEP: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wr_exit && mr1_q[wl_pkg::MR1_WL_BIT]) |=> (mr1_q == $past(wr_val)))
      else $error("exit write bits dropped");

   AST_AFTER: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wr_exit && in_level) |=> ##1 (dq_undef && dq_oe_q == '0) [*8])
      else $error("data defined too early after exit");

   AST_NOSTB: assert property (@(posedge sys_clk) disable iff (!nrst)
      wl_act_q |-> (strobe_oe == '0))
      else $error("read strobe driven in leveling");
endmodule // wl_level
`default_nettype wire

/* wl_ctrl_model.sv */
// Memory controller model that sweeps strobe timing per lane
`timescale 1ns/100ps
`default_nettype none
module wl_ctrl_model #(
   parameter int LANES = 2
) (
   input  wire logic                  sys_clk,
   input  wire logic                  nrst,
   input  wire logic                  go,
   input  wire logic                  drive,
   input  wire logic                  odt_en,
   input  wire logic [LANES-1:0][2:0] delay,
   output logic                       ck_level,
   output logic                       odt,
   output logic      [LANES-1:0]      strobe
);
   logic [2:0]       cnt_q;
   logic [LANES-1:0] armed_q;
   logic [LANES-1:0] pulse_q;

   // Free running device clock, eight cycles a period
   assign ck_level = cnt_q[2];

   assign strobe = drive ? pulse_q : '0;  // Released strobe rests low, no edge

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cnt_q   <= 3'h0;
         armed_q <= '0;
         pulse_q <= '0;
         odt     <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
         odt   <= odt_en;  // Raised by the bench only after settling
         for (int l = 0; l < LANES; l++) begin
            pulse_q[l] <= armed_q[l] && (cnt_q == delay[l]);
            if (go) begin
               armed_q[l] <= 1'b1;
            end else if (cnt_q == delay[l]) begin
               armed_q[l] <= 1'b0;
            end
         end
      end
   end
endmodule  // wl_ctrl_model
`default_nettype wire

/* tb_wl_level.sv */
// Self-checking bench of the write leveling block
`timescale 1ns/100ps
`default_nettype none
module tb_wl_level;
   localparam int          DQW    = 16;
   localparam int          SETTLE = wl_pkg::MODE_SET_CYC + 6;
   localparam logic [31:0] PARK   = 32'h0000_0020;
   localparam logic [7:0]  MR1    = wl_pkg::ADDR_MR1;
   localparam logic [7:0]  STS    = wl_pkg::ADDR_STATUS;

   logic             sys_clk = 1'b0;
   logic             nrst    = 1'b0;
   logic [7:0]       paddr   = 8'h00;
   logic             psel    = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite  = 1'b0;
   logic [31:0]      pwdata  = 32'h0000_0000;
   logic             go      = 1'b0;
   logic             drive   = 1'b1;
   logic             odt_en  = 1'b0;
   logic [1:0][2:0]  delay   = '0;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             ck_level;
   logic             odt;
   logic [1:0]       strobe;
   logic [DQW-1:0]   dq_o;
   logic [DQW-1:0]   dq_oe;
   logic [1:0]       strobe_oe;
   logic             dqs_term_nom;
   logic             dqs_term_park;
   logic             dq_term_on;
   logic             dq_undef;
   logic             wl_active;
   int               err_count = 0;
   int               cmp_count = 0;
   int               cycles    = 0;
   int               lock      = 8;
   logic             prev      = 1'b0;
   logic             lv0;
   logic             lv1;

   wl_level #(.LANES(2), .LANE_BITS(8)) wl_level_i (
      .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ck_level(ck_level), .odt(odt), .strobe(strobe), .dq_o(dq_o),
      .dq_oe(dq_oe), .strobe_oe(strobe_oe), .dqs_term_nom(dqs_term_nom),
      .dqs_term_park(dqs_term_park), .dq_term_on(dq_term_on),
      .dq_undef(dq_undef), .wl_active(wl_active));

   wl_ctrl_model #(.LANES(2)) wl_ctrl_model_i (
      .sys_clk(sys_clk), .nrst(nrst), .go(go), .drive(drive),
      .odt_en(odt_en), .delay(delay), .ck_level(ck_level), .odt(odt),
      .strobe(strobe));

   // Clock generation
   always #(wl_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

   // Hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         $display("unexpected timeout at %0t: %h vs %h", $time, cycles, 0);
         end_of_test();
      end
   end

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd  = prdata;
      err = pslverr;
      if (n >= 50) begin
         chk(32'(n), 32'h0000_0000);
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Register write and checked read
   task automatic wrc(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        e;
      apb(1'b1, a, d, rd, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
      logic [31:0] rd;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, rd, e);
      chk(rd, x);
      chk(32'(e), 32'(xe));
   endtask

   // One strobe request to the controller, then wait for feedback
   task automatic pulse();
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (16) @(posedge sys_clk);
   endtask

   // Verdict
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      rdc(MR1, 32'h0000_0000, 1'b0);
      rdc(STS, PARK, 1'b0);
      chk(32'(dq_term_on), 32'h0000_0001);
      rdc(8'h08, 32'h0000_0000, 1'b1);
      wrc(STS, 32'h0000_ffff);
      rdc(STS, PARK, 1'b0);
      $display("test reset_and_map done");
      wrc(MR1, 32'h0000_0080);
      pulse();
      chk(32'({wl_active, dq_undef, dq_term_on}), 32'h0000_0006);
      chk({dq_oe, 14'h0000, strobe_oe}, 32'h0000_0000);
      repeat (SETTLE) @(posedge sys_clk);
      odt_en <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(32'({dqs_term_nom, dqs_term_park, dq_term_on}), 32'h0000_0004);
      $display("test entry done");
      for (int d = 0; d < 8; d++) begin
         delay[0] <= 3'(d);
         delay[1] <= 3'(d + 4);
         pulse();
         lv0 = ((d + 1) % 8) >= 4;
         lv1 = ((d + 5) % 8) >= 4;
         chk({dq_oe, dq_o}, {16'hffff, {8{lv1}}, {8{lv0}}});
         chk(32'(dq_undef), 32'h0000_0000);
         if (prev === 1'b0 && dq_o[0] === 1'b1 && lock == 8) begin
            lock = d;
         end
         prev = dq_o[0];
      end
      chk(32'(lock), 32'h0000_0003);
      repeat (8) @(posedge sys_clk);
      chk(32'(dq_o), 32'h0000_ff00);
      rdc(STS, 32'h0000_0019, 1'b0);
      $display("test sweep done");
      wrc(MR1, 32'h0000_1083);
      rdc(MR1, 32'h0000_1080, 1'b0);
      repeat (4) @(posedge sys_clk);
      chk(32'(dq_oe), 32'h0000_0000);
      wrc(MR1, 32'h0000_0080);
      pulse();
      chk(32'(dq_oe), 32'h0000_ffff);
      $display("test output_off done");
      drive  <= 1'b0;
      odt_en <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(32'(dqs_term_nom), 32'h0000_0000);
      chk(32'({dqs_term_park, dq_term_on}), 32'h0000_0002);
      wrc(MR1, 32'h0000_0002);
      // Status outputs trail the taking edge by one cycle
      repeat (2) @(posedge sys_clk);
      chk(32'({wl_active, dq_undef, dq_oe}), 32'h0001_0000);
      rdc(MR1, 32'h0000_0002, 1'b0);
      repeat (SETTLE) @(posedge sys_clk);
      chk(32'({dq_undef, dq_term_on}), 32'h0000_0001);
      drive <= 1'b1;
      pulse();
      chk({dq_oe, dq_o}, 32'h0000_0000);
      $display("test exit done");
      end_of_test();
   end
endmodule  // tb_wl_level
`default_nettype wire
